/* File: design/abd_bridge.sv */
// AHB to APB bridge with table address decode and access screening
`timescale 1ns/1ps
`default_nettype none
`include "abd_params.svh"
//
// Contract
// - Sixteen slaves, own entry and select each
// - Ten low address bits checked against bounds
// - In-range hit selects port at entry index
// - Disabled entry: no select, OKAY answer
// - Protected entry, user access: ERROR, no select
// - Optional registers on read/write data paths
module abd_bridge import abd_pkg::*; #(
   parameter bit PIPE = 1'b0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Decode table
   input wire abd_entry_type cfg_table [`ABD_NSLV],
   // AHB slave side
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [3:0] hprot,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hready_out,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   // APB master side
   output logic [`ABD_NSLV-1:0] psel,
   output logic penable,
   output logic [31:0] paddr,
   output logic pwrite,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata [`ABD_NSLV]
);

   // Range hit for one table entry
   function automatic logic abd_hit(input abd_entry_type e,
                                    input logic [9:0] a);
      abd_hit = (a >= e.first_addr) && (a <= e.last_addr);
   endfunction : abd_hit

   abd_state_type state_q;
   logic [3:0] port_q;
   logic write_q;
   logic [31:0] addr_q;
   logic start;
   logic found;
   abd_entry_type ent;
   logic [31:0] wdata_sel;
   logic [31:0] rdata_mux;

   // Valid transfer presented to the bridge
   assign start = hsel && hready && htrans[1];

   // First matching entry wins; later overlaps are shadowed
   always_comb begin
      found = 1'b0;
      ent = '0;
      for (int i = 0; i < `ABD_NSLV; i++) begin
         if (!found && abd_hit(cfg_table[i],
                               haddr[`ABD_DEC_BITS-1:0])) begin
            found = 1'b1;
            ent = cfg_table[i];
         end
      end
   end

   // Transfer sequencer
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ABD_IDLE;
         port_q <= '0;
         write_q <= 1'b0;
         addr_q <= '0;
      end else begin
         case (state_q)
            ABD_IDLE: begin
               if (start) begin
                  addr_q <= haddr;
                  write_q <= hwrite;
                  port_q <= ent.index;
                  if (found && ent.enable) begin
                     if (ent.prot && !hprot[1])
                        state_q <= ABD_ERR1;
                     else
                        state_q <= ABD_SETUP;
                  end
                  // Disabled or unmapped: stay idle, OKAY
               end
            end
            ABD_SETUP: state_q <= ABD_ACCESS;
            ABD_ACCESS: state_q <= ABD_IDLE;
            ABD_ERR1: state_q <= ABD_ERR2;
            ABD_ERR2: state_q <= ABD_IDLE;
            default: state_q <= ABD_IDLE;
         endcase
      end
   end

   // Select only in setup and access phases
   always_comb begin
      psel = '0;
      if (state_q == ABD_SETUP || state_q == ABD_ACCESS)
         psel[port_q] = 1'b1;
   end
   assign penable = (state_q == ABD_ACCESS);
   assign paddr = addr_q;
   assign pwrite = write_q;
   assign rdata_mux = prdata[port_q];

   // Two-cycle error answer as AHB requires
   assign hresp = (state_q == ABD_ERR1 || state_q == ABD_ERR2) ?
                  `ABD_HRESP_ERROR : `ABD_HRESP_OKAY;
   assign hready_out = (state_q == ABD_IDLE) || (state_q == ABD_ERR2)
                       || (!PIPE && state_q == ABD_ACCESS);

   // Data paths, registered only with the pipe option
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wdata_q <= '0;
         rdata_q <= '0;
      end else begin
         if (state_q == ABD_IDLE || state_q == ABD_SETUP)
            wdata_q <= hwdata;
         if (state_q == ABD_ACCESS)
            rdata_q <= rdata_mux;
      end
   end

   // Pipe costs one extra wait on reads and writes alike
   assign wdata_sel = PIPE ? wdata_q : hwdata;
   assign pwdata = wdata_sel;
   assign hrdata = PIPE ? rdata_q : rdata_mux;

   // With pipe the access cycle is followed by one idle, ready cycle, flagged by tail_q
   logic tail_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         tail_q <= 1'b0;
      else
         tail_q <= PIPE && state_q == ABD_ACCESS;
   end

   // Phase order on the peripheral side
   a_setup_then_access: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      state_q == ABD_SETUP |=> penable && |psel)
      else $error("setup not followed by access");
   a_sel_two_cycles: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      state_q == ABD_SETUP |=> psel == $past(psel))
      else $error("select changed between setup and access");
   a_enable_with_sel: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      penable |-> |psel)
      else $error("enable strobe without select");
   a_enable_one_cycle: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      penable |=> !penable)
      else $error("enable strobe longer than one cycle");
   a_addr_held: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      state_q == ABD_SETUP |=> $stable(paddr) && $stable(pwrite))
      else $error("address or direction moved in access");
   a_setup_waits: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      state_q == ABD_SETUP |-> !hready_out && hresp == `ABD_HRESP_OKAY)
      else $error("setup cycle not a wait state");

   // Screening: errors, disabled and unmapped ranges
   a_error_no_select: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      hresp == `ABD_HRESP_ERROR |-> psel == '0)
      else $error("select during error answer");
   a_disabled_quiet: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      state_q == ABD_IDLE && start && found && !ent.enable
      |=> psel == '0 && hresp == `ABD_HRESP_OKAY)
      else $error("disabled entry selected");
   a_unmapped_quiet: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      state_q == ABD_IDLE && start && !found
      |=> psel == '0 && hresp == `ABD_HRESP_OKAY && hready_out)
      else $error("unmapped access not answered quietly");
   a_prot_user_err: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      state_q == ABD_IDLE && start && found && ent.enable &&
      ent.prot && !hprot[1] |=> hresp == `ABD_HRESP_ERROR && !hready_out
      ##1 hresp == `ABD_HRESP_ERROR && hready_out)
      else $error("user access to protected slave");

   // Decode: one select, at the entry's port
   a_one_hot_select: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $onehot0(psel))
      else $error("more than one select");
   a_hit_index: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      state_q == ABD_IDLE && start && found && ent.enable &&
      !(ent.prot && !hprot[1]) |=> psel[$past(ent.index)] && !penable)
      else $error("wrong select for hit");

   // Data paths with and without the pipe option
   a_pipe_read: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      PIPE && state_q == ABD_ACCESS |=> hrdata == $past(rdata_mux))
      else $error("piped read data wrong");
   a_pipe_waits: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      PIPE && state_q == ABD_ACCESS |-> !hready_out)
      else $error("piped access cycle not a wait state");
   a_flow_read: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      !PIPE |-> hrdata == rdata_mux && pwdata == hwdata)
      else $error("unpiped data path registered");
   a_unused_tail: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      tail_q |-> state_q == ABD_IDLE && hready_out)
      else $error("pipe tail not idle");

endmodule : abd_bridge
`default_nettype wire

/* File: design/abd_params.svh */
// Constants for the peripheral bridge decode block
`ifndef ABD_PARAMS_SVH
`define ABD_PARAMS_SVH
`define ABD_NSLV 16
`define ABD_DEC_BITS 10
`define ABD_IDX_BITS 4
`define ABD_HTRANS_NONSEQ 2'h2
`define ABD_HTRANS_SEQ 2'h3
`define ABD_HRESP_OKAY 2'h0
`define ABD_HRESP_ERROR 2'h1
`endif

/* File: design/abd_pkg.sv */
// Types for the peripheral bridge decode block
package abd_pkg;
   typedef struct packed {
      logic [9:0] first_addr;
      logic [9:0] last_addr;
      logic [3:0] index;
      logic enable;
      logic prot;
   } abd_entry_type;
   typedef enum {ABD_IDLE, ABD_SETUP, ABD_ACCESS, ABD_ERR1, ABD_ERR2}
      abd_state_type;
endpackage : abd_pkg

/* File: tb/abd_slaves.sv */
// Peripheral slave models answering the bridge
`timescale 1ns/1ps
`default_nettype none
module abd_slaves (
   // Peripheral bus from the bridge
   input wire logic [15:0] psel,
   input wire logic penable,
   input wire logic [31:0] paddr,
   // Read data back
   output logic [31:0] prdata [16]
);
   // Idle slaves drive the inverse, so stale data never passes
   always_comb begin
      for (int p = 0; p < 16; p++) begin
         prdata[p] = {4'(p), paddr[27:0]};
         if (!(psel[p] && penable)) prdata[p] = ~prdata[p];
      end
   end
endmodule : abd_slaves
`default_nettype wire

/* File: tb/ahb_to_apb_bridge_decode_bench.sv */
// Self-checking bench for the bridge decode block
`timescale 1ns/1ps
`default_nettype none
`include "abd_params.svh"
module ahb_to_apb_bridge_decode_bench import abd_pkg::*;;
   logic ref_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic hready = 1'b1, hready_out, penable, pwrite;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, paddr, pwdata;
   logic [1:0] htrans = 2'h0, hresp;
   logic [3:0] hprot = 4'h0;
   logic [15:0] psel;
   logic [31:0] prdata [16];
   logic hready_p, penable_p, pwrite_p;
   logic [1:0] hresp_p;
   logic [15:0] psel_p;
   logic [31:0] hrdata_p, paddr_p, pwdata_p;
   logic [31:0] prdata_p [16];
   abd_entry_type cfg_table [16];
   int bad_count = 0;
   int tests_run = 0;
   always #20 ref_clk = ~ref_clk;
   abd_bridge #(.PIPE(1'b0)) dut (.ref_clk, .nrst, .cfg_table, .hsel,
      .haddr, .htrans, .hwrite, .hprot, .hwdata, .hready, .hready_out,
      .hresp, .hrdata, .psel, .penable, .paddr, .pwrite, .pwdata, .prdata);
   // Same stimulus into a bridge with the pipe option
   abd_bridge #(.PIPE(1'b1)) dut_pipe (.ref_clk, .nrst, .cfg_table, .hsel,
      .haddr, .htrans, .hwrite, .hprot, .hwdata, .hready,
      .hready_out(hready_p), .hresp(hresp_p), .hrdata(hrdata_p),
      .psel(psel_p), .penable(penable_p), .paddr(paddr_p),
      .pwrite(pwrite_p), .pwdata(pwdata_p), .prdata(prdata_p));
   abd_slaves slv (.psel, .penable, .paddr, .prdata);
   abd_slaves slv_pipe (.psel(psel_p), .penable(penable_p), .paddr(paddr_p),
      .prdata(prdata_p));
   // Expected selects: reversed ports, slot 3 off, slot 5 guarded
   function automatic logic [15:0] exp_sel(input int i, input logic usr);
      if (i > 15 || i == 3 || (i == 5 && usr)) return 16'h0;
      return 16'h1 << (15 - i);
   endfunction : exp_sel
   // Read data the slave model returns at the entry's port
   function automatic logic [31:0] exp_rd(input int i, input logic [31:0] a);
      return {4'(15 - i), a[27:0]};
   endfunction : exp_rd
   task automatic chk(input string what, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // One transfer into slot i; slot 16 lies outside every range
   task automatic xfer(input int i, input logic usr);
      logic [15:0] es;
      logic [31:0] a;
      logic [31:0] er;
      logic quiet;
      es = exp_sel(i, usr);
      er = (i == 5 && usr) ? 32'(`ABD_HRESP_ERROR) : 32'(`ABD_HRESP_OKAY);
      quiet = (es == 16'h0) && (er == 32'(`ABD_HRESP_OKAY));
      a = $urandom;
      a[9:0] = 10'(i * 16) + 10'($urandom % 16);
      @(negedge ref_clk);
      hsel = 1'b1;
      htrans = `ABD_HTRANS_NONSEQ;
      haddr = a;
      hprot = {2'h0, ~usr, 1'b1};
      hwrite = 1'($urandom);
      @(negedge ref_clk);
      hsel = 1'b0;
      htrans = 2'h0;
      hwdata = ~a;
      chk("psel", 32'({es, es}), 32'({psel, psel_p}));
      chk("hresp first", er, 32'(hresp));
      chk("hresp pipe first", er, 32'(hresp_p));
      chk("ready first", 32'({quiet, quiet}),
         32'({hready_out, hready_p}));
      if (es !== 16'h0) chk("paddr", a, paddr);
      @(negedge ref_clk);
      chk("hresp second", er, 32'(hresp));
      chk("hresp pipe second", er, 32'(hresp_p));
      chk("ready second", 32'({1'b1, es == 16'h0}),
         32'({hready_out, hready_p}));
      if (es !== 16'h0) begin
         chk("penable", 32'h3, 32'({penable, penable_p}));
         chk("pwrite", 32'({hwrite, hwrite}),
            32'({pwrite, pwrite_p}));
         chk("paddr pipe", a, paddr_p);
         if (hwrite) begin
            chk("pwdata", ~a, pwdata);
            chk("pwdata pipe", ~a, pwdata_p);
         end else begin
            chk("hrdata", exp_rd(i, a), hrdata);
         end
      end
      @(negedge ref_clk);
      chk("hresp idle", 32'h0, 32'({hresp, hresp_p}));
      chk("ready idle", 32'h3, 32'({hready_out, hready_p}));
      chk("psel idle", 32'h0, 32'({psel, psel_p}));
      if (es !== 16'h0 && !hwrite) begin
         chk("hrdata pipe", exp_rd(i, a), hrdata_p);
      end
   endtask : xfer
   // Reset in mid-transfer: select, enable, ready, response and address fall back at once
   task automatic cut();
      @(negedge ref_clk);
      hsel = 1'b1;
      htrans = `ABD_HTRANS_NONSEQ;
      haddr = $urandom;
      haddr[9:0] = 10'h075;
      hprot = 4'h3;
      @(negedge ref_clk);
      hsel = 1'b0;
      htrans = 2'h0;
      nrst = 1'b0;
      @(negedge ref_clk);
      chk("psel in reset", 32'h0, 32'({psel, psel_p}));
      chk("penable in reset", 32'h0, 32'({penable, penable_p}));
      chk("ready in reset", 32'h3, 32'({hready_out, hready_p}));
      chk("hresp in reset", 32'h0, 32'({hresp, hresp_p}));
      chk("paddr in reset", 32'h0, paddr | paddr_p);
      nrst = 1'b1;
   endtask : cut
   // Ascending ranges, reversed ports, slot 3 off, slot 5 guarded
   initial begin
      void'($urandom(32'h7E56));
      for (int i = 0; i < 16; i++) begin
         cfg_table[i] = '{10'(i * 16), 10'(i * 16 + 15), 4'(15 - i),
            i != 3, i == 5};
      end
      repeat (8) @(negedge ref_clk);
      nrst = 1'b1;
      for (int u = 0; u < 2; u++) begin
         for (int i = 0; i <= 16; i++) xfer(i, u[0]);
         if (u == 0) cut();
      end
      conclude();
   end
   // Tests take about 150 cycles; give up after 500
   initial begin
      #20000;
      bad_count++;
      conclude();
   end
endmodule : ahb_to_apb_bridge_decode_bench
`default_nettype wire
